// File: design/softstart_survival_pkg.sv
// Constants for the soft-start and survival sequencer
package softstart_survival_pkg;
	localparam int CLOCK_HZ = 200_000_000;
	localparam int RUN_DELAY_NS = 2200;
	localparam int RUN_DELAY_CYCLES = (RUN_DELAY_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
	localparam int TIMEOUT_US_X10 = 7000;
	localparam int TIMEOUT_CYCLES_DFLT = (TIMEOUT_US_X10 / 10) * (CLOCK_HZ / 1_000_000);
	localparam logic [2:0] FIRST_LEVEL_PULSES = 3'h5;
	localparam int CNT_W = 20;
	localparam logic [1:0] LIMIT_FIRST = 2'h0;
	localparam logic [1:0] LIMIT_SECOND = 2'h1;
	localparam logic [1:0] LIMIT_MAX = 2'h2;
	localparam logic [1:0] LIMIT_LOOP = 2'h3;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WAKE = 3'b001,
		ST_SOFT = 3'b010,
		ST_NORMAL = 3'b011,
		ST_SURVIVE = 3'b100
	} seq_state_t;
endpackage

// File: design/softstart_survival_sequencer.sv
// Soft-start peak-limit sequencer and supply survival regulator
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Wait 2.2us and supply good before pulsing
// - Soft-start limits first 0.2V then 0.5V
// - First level: no high-side below 0.28V sense
// - First five low-side pulses stay at first
// - Second level after 0.28V and five pulses
// - Force second level after 0.7ms timeout
// - Above 0.5V sense allow maximum level
// - Near target, loop lowers limit; soft-start ends
// - Survival regulator only while feedback stops
// - Survival: pulse below 13V, stop above
// - Survival threshold is turn-off plus margin
// - Feedback resumes: return to normal pulses
module softstart_survival_sequencer #(
	parameter int TIMEOUT_CYCLES = softstart_survival_pkg::TIMEOUT_CYCLES_DFLT
) (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       clockEnable,
	input  wire logic       runLevel,
	input  wire logic       secondarySupplyGood,
	input  wire logic       auxSenseAbove028,
	input  wire logic       auxSenseAbove050,
	input  wire logic       nearRegulation,
	input  wire logic       supplyBelowSurvival,
	input  wire logic       feedbackStopRequest,
	input  wire logic       lowPulseRequest,
	input  wire logic       highPulseRequest,
	output logic [1:0]      peakLimitSelect,
	output logic            lowSideGatePulse,
	output logic            highSideGatePulse,
	output logic            softStartActive,
	output logic            survivalActive
);
	localparam int NF = 7;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [NF-1:0] rawFlags;
	logic [NF-1:0] syncA_q;
	logic [NF-1:0] syncB_q;
	logic [NF-1:0] syncC_q;
	logic [NF-1:0] flags_q;

	assign rawFlags[6] = runLevel;
	assign rawFlags[5] = secondarySupplyGood;
	assign rawFlags[4] = auxSenseAbove028;
	assign rawFlags[3] = auxSenseAbove050;
	assign rawFlags[2] = nearRegulation;
	assign rawFlags[1] = supplyBelowSurvival;
	assign rawFlags[0] = feedbackStopRequest;

	// Three stages; only stage B reads stage A
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			syncA_q <= '0;
			syncB_q <= '0;
			syncC_q <= '0;
		end else if (clockEnable) begin
			syncA_q <= rawFlags;
			syncB_q <= syncA_q;
			syncC_q <= syncB_q;
		end
	end

	// Stage B and C must agree before a change counts
	// Costs a cycle of latency but rejects single-cycle glitches
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= '0;
		end else if (clockEnable) begin
			for (int i = 0; i < NF; i++) begin
				if (syncB_q[i] == syncC_q[i]) begin
					flags_q[i] <= syncC_q[i];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Filtered flags
	// ------------------------------------------------------------
	logic          runF;
	logic          supplyGoodF;
	logic          above028F;
	logic          above050F;
	logic          nearRegF;
	logic          belowSurvF;
	logic          fbStopF;

	assign runF = flags_q[6];
	assign supplyGoodF = flags_q[5];
	assign above028F = flags_q[4];
	assign above050F = flags_q[3];
	assign nearRegF = flags_q[2];
	assign belowSurvF = flags_q[1];
	assign fbStopF = flags_q[0];

	// ------------------------------------------------------------
	// Sequencer state
	// ------------------------------------------------------------
	softstart_survival_pkg::seq_state_t state_q;
	logic [softstart_survival_pkg::CNT_W-1:0] timer_q;
	logic [2:0] pulseCount_q;
	logic [1:0] limit_q;
	logic firstDone;
	logic timedOut;
	logic runDelayDone;

	assign firstDone = (pulseCount_q >= softstart_survival_pkg::FIRST_LEVEL_PULSES) && above028F;
	assign timedOut = (timer_q >= softstart_survival_pkg::CNT_W'(TIMEOUT_CYCLES - 1));
	assign runDelayDone = (timer_q >= softstart_survival_pkg::CNT_W'(softstart_survival_pkg::RUN_DELAY_CYCLES - 1));

	// ------------------------------------------------------------
	// State machine
	// ------------------------------------------------------------

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= softstart_survival_pkg::ST_IDLE;
		end else if (clockEnable) begin
			if (!runF) begin
				state_q <= softstart_survival_pkg::ST_IDLE;
			end else begin
				case (state_q)
					softstart_survival_pkg::ST_IDLE: begin
						state_q <= softstart_survival_pkg::ST_WAKE;
					end
					softstart_survival_pkg::ST_WAKE: begin
						if (runDelayDone && supplyGoodF) begin
							state_q <= softstart_survival_pkg::ST_SOFT;
						end
					end
					softstart_survival_pkg::ST_SOFT: begin
						if (limit_q == softstart_survival_pkg::LIMIT_MAX && nearRegF) begin
							state_q <= softstart_survival_pkg::ST_NORMAL;
						end
					end
					softstart_survival_pkg::ST_NORMAL: begin
						if (fbStopF) begin
							state_q <= softstart_survival_pkg::ST_SURVIVE;
						end
					end
					softstart_survival_pkg::ST_SURVIVE: begin
						if (!fbStopF) begin
							state_q <= softstart_survival_pkg::ST_NORMAL;
						end
					end
					default: begin
						state_q <= softstart_survival_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Wake and timeout timer
	// ------------------------------------------------------------
	// Timer serves both the wake delay and the soft-start timeout
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			timer_q <= '0;
		end else if (clockEnable) begin
			if (!runF || state_q == softstart_survival_pkg::ST_IDLE
					|| (state_q == softstart_survival_pkg::ST_WAKE && runDelayDone && supplyGoodF)) begin
				timer_q <= '0;
			end else if (state_q == softstart_survival_pkg::ST_WAKE) begin
				// Own stop point: the timeout may be shorter than the wake delay
				if (!runDelayDone) begin
					timer_q <= timer_q + 1'b1;
				end
			end else if (!timedOut) begin
				timer_q <= timer_q + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Soft-start pulse counter
	// ------------------------------------------------------------
	// Saturating count of low-side pulses since soft-start began
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pulseCount_q <= '0;
		end else if (clockEnable) begin
			if (state_q != softstart_survival_pkg::ST_SOFT) begin
				pulseCount_q <= '0;
			end else if (lowSideGatePulse
					&& pulseCount_q < softstart_survival_pkg::FIRST_LEVEL_PULSES) begin
				pulseCount_q <= pulseCount_q + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Peak-limit selection
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			limit_q <= softstart_survival_pkg::LIMIT_FIRST;
		end else if (clockEnable) begin
			if (state_q == softstart_survival_pkg::ST_SOFT) begin
				if (limit_q == softstart_survival_pkg::LIMIT_FIRST) begin
					if (firstDone || timedOut) begin
						limit_q <= softstart_survival_pkg::LIMIT_SECOND;
					end
				end else if (above050F) begin
					limit_q <= softstart_survival_pkg::LIMIT_MAX;
				end
			end else if (state_q == softstart_survival_pkg::ST_NORMAL
					|| state_q == softstart_survival_pkg::ST_SURVIVE) begin
				limit_q <= softstart_survival_pkg::LIMIT_LOOP;
			end else begin
				limit_q <= softstart_survival_pkg::LIMIT_FIRST;
			end
		end
	end

	// ------------------------------------------------------------
	// Gate pulse outputs
	// ------------------------------------------------------------
	// Requests come from the same clock, so they bypass the synchronisers
	logic lowPulse_d;
	logic highPulse_d;

	always_comb begin
		lowPulse_d = 1'b0;
		highPulse_d = 1'b0;
		case (state_q)
			softstart_survival_pkg::ST_SOFT: begin
				lowPulse_d = lowPulseRequest;
				// High side held off at first level until sense is high enough
				highPulse_d = highPulseRequest
					&& !(limit_q == softstart_survival_pkg::LIMIT_FIRST && !above028F);
			end
			softstart_survival_pkg::ST_NORMAL: begin
				lowPulse_d = lowPulseRequest;
				highPulse_d = highPulseRequest;
			end
			softstart_survival_pkg::ST_SURVIVE: begin
				// Comparator already trips at turn-off level plus margin; no count cap
				lowPulse_d = belowSurvF;
				highPulse_d = 1'b0;
			end
			default: begin
				lowPulse_d = 1'b0;
				highPulse_d = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	// Registered so the gate driver never sees decode glitches
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lowSideGatePulse <= 1'b0;
		end else if (clockEnable) begin
			lowSideGatePulse <= lowPulse_d;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			highSideGatePulse <= 1'b0;
		end else if (clockEnable) begin
			highSideGatePulse <= highPulse_d;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			peakLimitSelect <= softstart_survival_pkg::LIMIT_FIRST;
		end else if (clockEnable) begin
			peakLimitSelect <= limit_q;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			softStartActive <= 1'b0;
		end else if (clockEnable) begin
			softStartActive <= (state_q == softstart_survival_pkg::ST_SOFT);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			survivalActive <= 1'b0;
		end else if (clockEnable) begin
			survivalActive <= (state_q == softstart_survival_pkg::ST_SURVIVE);
		end
	end
endmodule // softstart_survival_sequencer
`default_nettype wire

// File: tb/softstart_monitor.sv
// Checker bound to the sequencer ports
`timescale 1ns/100ps
`default_nettype none
module softstart_monitor #(
	parameter int TIMEOUT_CYCLES = 200
) (
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic       runLevel,
	input wire logic       secondarySupplyGood,
	input wire logic       auxSenseAbove028,
	input wire logic       auxSenseAbove050,
	input wire logic       supplyBelowSurvival,
	input wire logic       feedbackStopRequest,
	input wire logic [1:0] peakLimitSelect,
	input wire logic       lowSideGatePulse,
	input wire logic       highSideGatePulse,
	input wire logic       softStartActive,
	input wire logic       survivalActive
);
	// ----
	// Helper counters; run and quiet counters saturate
	// ----
	logic [9:0] runCnt_q;
	logic [2:0] quietCnt_q;
	int         firstCnt_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			runCnt_q   <= '0;
			quietCnt_q <= '0;
			firstCnt_q <= 0;
		end else begin
			runCnt_q   <= !runLevel ? '0 : runCnt_q + 10'(runCnt_q != '1);
			quietCnt_q <= supplyBelowSurvival ? '0 : quietCnt_q + 3'(quietCnt_q != '1);
			firstCnt_q <= (softStartActive && peakLimitSelect == 2'h0) ? firstCnt_q + 1 : 0;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_wake; $rose(softStartActive) |-> runCnt_q > 10'd440 && secondarySupplyGood; endproperty
	a_wake: assert property (p_wake) else $error("soft-start too early");
	property p_highFirst; softStartActive && peakLimitSelect == 2'h0 && highSideGatePulse |-> $past(auxSenseAbove028, 5); endproperty
	a_highFirst: assert property (p_highFirst) else $error("high side at first level");
	property p_order; softStartActive && $past(peakLimitSelect) == 2'h0 && peakLimitSelect != 2'h0 |-> peakLimitSelect == 2'h1; endproperty
	a_order: assert property (p_order) else $error("first level not left for second");
	property p_timeout; firstCnt_q <= TIMEOUT_CYCLES + 8; endproperty
	a_timeout: assert property (p_timeout) else $error("first level held too long");
	property p_max; softStartActive && peakLimitSelect == 2'h2 |-> auxSenseAbove050; endproperty
	a_max: assert property (p_max) else $error("maximum without sense");
	property p_loop; peakLimitSelect == 2'h3 |-> !softStartActive; endproperty
	a_loop: assert property (p_loop) else $error("loop limit in soft-start");
	property p_survIn; $rose(survivalActive) |-> feedbackStopRequest; endproperty
	a_survIn: assert property (p_survIn) else $error("survival without stop request");
	property p_survLow; survivalActive && $past(survivalActive) && lowSideGatePulse |-> quietCnt_q < 3'd7; endproperty
	a_survLow: assert property (p_survLow) else $error("survival pulse above threshold");
	property p_survHigh; survivalActive && $past(survivalActive) |-> !highSideGatePulse; endproperty
	a_survHigh: assert property (p_survHigh) else $error("high side in survival");
endmodule // softstart_monitor
bind softstart_survival_sequencer softstart_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) mon (.*);
`default_nettype wire

// File: tb/power_stage_model.sv
// Power stage model: aux sense builds up with low-side pulses
`timescale 1ns/100ps
`default_nettype none
module power_stage_model (
	input  wire logic clock,
	input  wire logic lowSideGatePulse,
	input  wire logic heavyLoad,
	output logic      auxSenseAbove028,
	output logic      auxSenseAbove050
);
	// Heavy load keeps the output from building up at all
	int pulses = 0;
	always @(posedge clock) pulses <= heavyLoad ? 0 : pulses + int'(lowSideGatePulse);
	assign auxSenseAbove028 = pulses >= 2;
	assign auxSenseAbove050 = pulses >= 8;
endmodule // power_stage_model
`default_nettype wire

// File: tb/softstart_survival_sequencer_tb_top.sv
// Testbench for the soft-start and survival sequencer
`timescale 1ns/100ps
`default_nettype none
module softstart_survival_sequencer_tb_top;
	logic clock = 0, rst_n = 0, runLevel = 0, supplyGood = 0, nearReg = 0, below = 0, fbStop = 0;
	logic lowReq = 0, highReq = 0, heavy = 0, ss, sv, lo, hi, above028, above050;
	logic [1:0] lim;
	int         errCount = 0, testsRun = 0, k;
	wire logic [4:0] obs = {lim, ss, sv, lo};
	initial forever #2.5 clock = ~clock;
	softstart_survival_sequencer #(.TIMEOUT_CYCLES(200)) dut (.clock(clock), .rst_n(rst_n), .clockEnable(1'b1),
		.runLevel(runLevel), .secondarySupplyGood(supplyGood), .auxSenseAbove028(above028),
		.auxSenseAbove050(above050), .nearRegulation(nearReg), .supplyBelowSurvival(below),
		.feedbackStopRequest(fbStop), .lowPulseRequest(lowReq), .highPulseRequest(highReq),
		.peakLimitSelect(lim), .lowSideGatePulse(lo), .highSideGatePulse(hi), .softStartActive(ss),
		.survivalActive(sv));
	power_stage_model stage (.clock(clock), .lowSideGatePulse(lo), .heavyLoad(heavy),
		.auxSenseAbove028(above028), .auxSenseAbove050(above050));
	// ----
	// Shared tasks
	// ----
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", testsRun, errCount);
		if (errCount == 0 && testsRun > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [4:0] got, input logic [4:0] exp);
		testsRun++;
		if (got !== exp) begin
			errCount++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Bounded wait; a timeout shows up as a mismatch
	task automatic wt(input logic [4:0] m, input logic [4:0] v, input int n);
		for (k = 0; k < n && (obs & m) !== v; k++) @(posedge clock);
		chk(obs & m, v);
		if (k == n) report_and_stop();
	endtask
	task automatic pulse(input int n);
		repeat (n) begin
			lowReq  <= 1;
			highReq <= 1;
			@(posedge clock);
			lowReq  <= 0;
			highReq <= 0;
			repeat (8) @(posedge clock);
		end
	endtask
	// One high-side request; the gate output stands for one cycle
	task automatic hi_probe(input logic exp);
		highReq <= 1;
		@(posedge clock);
		highReq <= 0;
		@(posedge clock);
		chk({4'h0, hi}, {4'h0, exp});
	endtask
	initial begin
		repeat (5) @(posedge clock);
		rst_n <= 1;
		@(posedge clock);
		runLevel <= 1;
		repeat (600) @(posedge clock);
		chk(obs & 5'h04, 5'h00);
		supplyGood <= 1;
		wt(5'h04, 5'h04, 20);
		$display("wake done");
		pulse(4);
		chk(obs & 5'h1c, 5'h04);
		pulse(1);
		wt(5'h18, 5'h08, 20);
		pulse(4);
		wt(5'h18, 5'h10, 20);
		nearReg <= 1;
		wt(5'h1c, 5'h18, 20);
		$display("soft-start done");
		fbStop <= 1;
		wt(5'h06, 5'h02, 20);
		below <= 1;
		wt(5'h01, 5'h01, 20);
		hi_probe(1'b0);
		pulse(1);
		chk(obs & 5'h03, 5'h03);
		below <= 0;
		wt(5'h01, 5'h00, 20);
		fbStop <= 0;
		wt(5'h06, 5'h00, 20);
		hi_probe(1'b1);
		$display("survival done");
		heavy    <= 1;
		nearReg  <= 0;
		runLevel <= 0;
		wt(5'h1c, 5'h00, 20);
		runLevel <= 1;
		wt(5'h04, 5'h04, 1000);
		repeat (150) @(posedge clock);
		chk(obs & 5'h18, 5'h00);
		hi_probe(1'b0);
		wt(5'h18, 5'h08, 100);
		$display("timeout done");
		report_and_stop();
	end
endmodule // softstart_survival_sequencer_tb_top
`default_nettype wire
